// ### logic/vrf_lane_merge.sv
// per-lane merge, zero and upper clear of a write-back value
`timescale 1ns/100ps
module vrf_lane_merge
  import vrf_pkg::*;
(
  vrf_merge_if.unit m
);
  vrf_lanes_t in_vl;

  always_comb
  begin
    in_vl = vrf_vl_lanes(m.vl);
    m.merged = '0;
    for (int i = 0; i < LANES; i++)
    begin
      if (!in_vl[i])
        m.merged[i*LANE_W +: LANE_W] = '0;
      else if (m.elem_en[i])
        m.merged[i*LANE_W +: LANE_W] = m.new_data[i*LANE_W +: LANE_W];
      else if (m.zero)
        m.merged[i*LANE_W +: LANE_W] = '0;
      else
        m.merged[i*LANE_W +: LANE_W] = m.old_data[i*LANE_W +: LANE_W];
        // merging by default
    end
  end
endmodule // vrf_lane_merge

// ### logic/vrf_merge_if.sv
// carrier between the register file and its lane merge unit
`timescale 1ns/100ps
interface vrf_merge_if;
  import vrf_pkg::*;
  logic [VLEN-1:0] new_data;
  logic [VLEN-1:0] old_data;
  logic [VLEN-1:0] merged;
  vrf_lanes_t      elem_en;
  logic            zero;
  logic [1:0]      vl;

  modport user (output new_data, output old_data, output elem_en,
                output zero, output vl, input merged);
  modport unit (input new_data, input old_data, input elem_en,
                input zero, input vl, output merged);
endinterface

// ### logic/vrf_pkg.sv
// constants, types and helpers shared by the vector register file
package vrf_pkg;
  localparam int          NUM_VREG     = 32;
  localparam int          NUM_VREG_LEG = 8;
  localparam int          VLEN         = 512;
  localparam int          YLEN         = 256;
  localparam int          XLEN         = 128;
  localparam int          NUM_KREG     = 8;
  localparam int          KLEN         = 64;
  localparam int          LANE_W       = 32;
  localparam int          LANES        = VLEN / LANE_W;
  localparam int          LANES_X      = XLEN / LANE_W;
  localparam int          LANES_Y      = YLEN / LANE_W;
  localparam int          QW_W         = 64;
  localparam int          CNT_W        = 16;

  // vector length codes from the decoder
  localparam logic [1:0]  VL_128       = 2'h0;
  localparam logic [1:0]  VL_256       = 2'h1;
  localparam logic [1:0]  VL_512       = 2'h2;

  localparam logic [2:0]  MASK_REG_ZERO = 3'h0;

  // apb map
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam int          CTRL_LONG    = 0;
  localparam int          CTRL_RND_LO  = 1;
  localparam int          CTRL_RND_HI  = 2;
  localparam logic        RST_LONG     = 1'b1;
  localparam logic [1:0]  RST_RND      = 2'h0;

  typedef logic [LANES-1:0] vrf_lanes_t;

  typedef struct packed {
    logic [NUM_VREG-1:0][VLEN-1:0] vreg;
    logic [NUM_KREG-1:0][KLEN-1:0] kreg;
    logic                          long_mode;
    logic [1:0]                    dflt_round;
    logic [CNT_W-1:0]              fault_cnt;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          rd_valid;
    logic                          rd_fault;
    logic [VLEN-1:0]               src1;
    logic [VLEN-1:0]               src2;
    logic [KLEN-1:0]               pred;
    logic [KLEN-1:0]               ksrc;
    vrf_lanes_t                    mem_en;
    logic [1:0]                    round;
  } vrf_state_t;

  // one enable per 32-bit lane; 64-bit elements cover two lanes
  function automatic vrf_lanes_t vrf_lane_en(input logic [KLEN-1:0] m,
                                             input logic            esz);
    vrf_lanes_t r;
    r = '0;
    for (int i = 0; i < LANES; i++)
    begin
      r[i] = esz ? m[i/2] : m[i];
    end
    return r;
  endfunction

  function automatic vrf_lanes_t vrf_vl_lanes(input logic [1:0] vl);
    vrf_lanes_t r;
    r = '0;
    for (int i = 0; i < LANES; i++)
    begin
      r[i] = (vl == VL_128) ? (i < LANES_X) :
             (vl == VL_256) ? (i < LANES_Y) : 1'b1;
    end
    return r;
  endfunction
endpackage

// ### logic/vrf_top.sv
// vector register file with predicate masks and apb control
`timescale 1ns/100ps
// Notes on behaviour
// - with long mode set there are 32 vector registers of 512 bits.
// - with long mode clear only vector indices 0..7 are legal.
// - the 256 and 128 bit views are the low bits of the same register.
// - eight separate 64-bit mask registers exist.
// - mask index zero as predicate means all elements are processed.
// - mask indices one to seven act as real conditional predicates.
// - one zeroing bit picks zeroing or merging for disabled elements.
// - with the zeroing bit clear, disabled elements are merged.
// - a 128-bit result clears destination bits 511:128.
// - a 256-bit result clears destination bits 511:256.
// - memory operand elements are moved only where the mask enables.
// - broadcast replicates one memory element over all lanes.
// - prefix rounding control overrides the default rounding.
// - mask registers are readable as sources and writable as flags.
// - the extended prefix on legacy integer or stack float is refused.
module vrf_top
  import vrf_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                dec_valid,
  input  wire logic                dec_ext_prefix,
  input  wire logic                dec_legacy_reg,
  input  wire logic [4:0]          dec_dst,
  input  wire logic [4:0]          dec_src1,
  input  wire logic [4:0]          dec_src2,
  input  wire logic [2:0]          dec_mask_idx,
  input  wire logic [2:0]          dec_ksrc,
  input  wire logic                dec_esz,
  input  wire logic [1:0]          dec_vl,
  input  wire logic                dec_mem_src,
  input  wire logic                dec_bcast,
  input  wire logic                dec_round_en,
  input  wire logic [1:0]          dec_round_mode,
  input  wire logic [VLEN-1:0]     mem_data,
  input  wire logic                wb_valid,
  input  wire logic [4:0]          wb_dst,
  input  wire logic [VLEN-1:0]     wb_data,
  input  wire logic [2:0]          wb_mask_idx,
  input  wire logic                wb_zero,
  input  wire logic                wb_esz,
  input  wire logic [1:0]          wb_vl,
  input  wire logic                wb_kvalid,
  input  wire logic [2:0]          wb_kdst,
  input  wire logic [KLEN-1:0]     wb_kdata,
  output logic                     rd_valid,
  output logic                     rd_fault,
  output logic      [VLEN-1:0]     rd_src1,
  output logic      [VLEN-1:0]     rd_src2,
  output logic      [KLEN-1:0]     rd_pred,
  output logic      [KLEN-1:0]     rd_ksrc,
  output vrf_lanes_t               mem_elem_en,
  output logic      [1:0]          rd_round
);
  vrf_state_t      s_q;
  vrf_state_t      s_d;
  vrf_merge_if     mif ();

  logic            apb_setup;
  logic            apb_access;
  logic            dec_fault;
  logic            wb_ok;
  logic [KLEN-1:0] pred_eff;
  logic [KLEN-1:0] wb_pred;
  vrf_lanes_t      lane_en_dec;
  logic [VLEN-1:0] mem_view;
  logic [VLEN-1:0] old_sel;

  // an index is legal when long mode is on or it lies in 0..7
  function automatic logic idx_ok(input logic [4:0] idx,
                                  input logic       lm);
    return lm || (idx < 5'(NUM_VREG_LEG));
  endfunction

  assign mif.new_data = wb_data;
  assign mif.old_data = old_sel;
  assign mif.elem_en  = vrf_lane_en(wb_pred, wb_esz);
  assign mif.zero     = wb_zero;
  assign mif.vl       = wb_vl;

  vrf_lane_merge u_merge (
    .m (mif.unit)
  );

  always_comb
  begin
    s_d        = s_q;
    apb_setup  = psel && !penable;
    apb_access = psel && penable && s_q.pready;

    // apb: zero wait, answer registered in the setup cycle
    s_d.pready  = apb_setup;
    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;
    if (apb_setup)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          s_d.prdata[CTRL_LONG]               = s_q.long_mode;
          s_d.prdata[CTRL_RND_HI:CTRL_RND_LO] = s_q.dflt_round;
        end
        OFS_STATUS:
          s_d.prdata[CNT_W-1:0] = s_q.fault_cnt;
        default:
          s_d.pslverr = 1'b1;
      endcase
    end
    if (apb_access && pwrite && paddr == OFS_CTRL)
    begin
      s_d.long_mode  = pwdata[CTRL_LONG];
      s_d.dflt_round = pwdata[CTRL_RND_HI:CTRL_RND_LO];
    end

    // predicate: index zero is unconditional
    pred_eff = (dec_mask_idx == MASK_REG_ZERO) ? '1 :
               s_q.kreg[dec_mask_idx];
    wb_pred  = (wb_mask_idx == MASK_REG_ZERO) ? '1 :
               s_q.kreg[wb_mask_idx];
    lane_en_dec = vrf_lane_en(pred_eff, dec_esz) & vrf_vl_lanes(dec_vl);

    // broadcast takes element 0 of the memory operand
    if (dec_bcast)
      mem_view = dec_esz ? {(VLEN/QW_W){mem_data[QW_W-1:0]}} :
                 {LANES{mem_data[LANE_W-1:0]}};
    else
      mem_view = mem_data;

    dec_fault = (dec_ext_prefix && dec_legacy_reg)
             || !idx_ok(dec_dst, s_q.long_mode)
             || !idx_ok(dec_src1, s_q.long_mode)
             || (!dec_mem_src && !idx_ok(dec_src2, s_q.long_mode));

    s_d.rd_valid = dec_valid;
    s_d.rd_fault = dec_valid && dec_fault;
    if (dec_valid && !dec_fault)
    begin
      s_d.src1 = s_q.vreg[dec_src1];
      s_d.pred = pred_eff;
      s_d.ksrc = s_q.kreg[dec_ksrc];
      s_d.round = (dec_ext_prefix && dec_round_en) ? dec_round_mode :
                  s_q.dflt_round;
      if (dec_mem_src)
      begin
        s_d.mem_en = lane_en_dec;
        for (int i = 0; i < LANES; i++)
        begin
          s_d.src2[i*LANE_W +: LANE_W] = lane_en_dec[i] ?
            mem_view[i*LANE_W +: LANE_W] : '0;
        end
      end
      else
      begin
        s_d.mem_en = '0;
        s_d.src2   = s_q.vreg[dec_src2];
      end
    end
    else
    begin
      s_d.mem_en = '0;
    end
    if (s_d.rd_fault)
      s_d.fault_cnt = s_q.fault_cnt + 1'b1;
    else if (apb_access && pwrite && paddr == OFS_STATUS)
      s_d.fault_cnt = '0;  // increment wins over a clear

    // write-back; a same-cycle decode read sees the old value
    wb_ok   = wb_valid && idx_ok(wb_dst, s_q.long_mode);
    old_sel = s_q.vreg[wb_dst];
    if (wb_ok)
      s_d.vreg[wb_dst] = mif.merged;
    if (wb_kvalid)
      s_d.kreg[wb_kdst] = wb_kdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q            <= '0;
      s_q.long_mode  <= RST_LONG;
      s_q.dflt_round <= RST_RND;
    end
    else
      s_q <= s_d;
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign rd_valid    = s_q.rd_valid;
  assign rd_fault    = s_q.rd_fault;
  assign rd_src1     = s_q.src1;
  assign rd_src2     = s_q.src2;
  assign rd_pred     = s_q.pred;
  assign rd_ksrc     = s_q.ksrc;
  assign mem_elem_en = s_q.mem_en;
  assign rd_round    = s_q.round;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SHORT_MODE: assert property (
    dec_valid && !s_q.long_mode && dec_src1 >= 5'(NUM_VREG_LEG)
    |=> rd_valid && rd_fault)
    else $error("high index accepted in short mode");
  AST_LONG_MODE: assert property (
    dec_valid && s_q.long_mode && !dec_mem_src && !dec_legacy_reg
    |=> !rd_fault)
    else $error("legal long-mode index faulted");
  AST_PRED_ZERO: assert property (
    dec_valid && !dec_fault && dec_mask_idx == MASK_REG_ZERO
    |=> rd_pred == '1)
    else $error("mask index zero did not give all ones");
  AST_PRED_REG: assert property (
    dec_valid && !dec_fault && dec_mask_idx != MASK_REG_ZERO
    && !wb_kvalid
    |=> rd_pred == s_q.kreg[$past(dec_mask_idx)])
    else $error("predicate not taken from mask register");
  AST_CLEAR128: assert property (
    wb_ok && wb_vl == VL_128
    |=> s_q.vreg[$past(wb_dst)][VLEN-1:XLEN] == '0)
    else $error("bits above 128 not cleared");
  AST_CLEAR256: assert property (
    wb_ok && wb_vl == VL_256
    |=> s_q.vreg[$past(wb_dst)][VLEN-1:YLEN] == '0)
    else $error("bits above 256 not cleared");
  AST_ZERO_MASK: assert property (
    wb_ok && wb_zero && mif.elem_en == '0
    |=> s_q.vreg[$past(wb_dst)] == '0)
    else $error("zeroing left data in disabled elements");
  AST_MERGE_KEEP: assert property (
    wb_ok && !wb_zero && wb_vl == VL_512 && mif.elem_en == '0
    |=> s_q.vreg[$past(wb_dst)] == $past(old_sel))
    else $error("merging changed disabled elements");
  AST_BCAST: assert property (
    dec_valid && !dec_fault && dec_mem_src && dec_bcast && !dec_esz
    && dec_mask_idx == MASK_REG_ZERO && dec_vl == VL_512
    |=> rd_src2 == {LANES{$past(mem_data[LANE_W-1:0])}})
    else $error("broadcast not replicated");
  AST_MEM_EN: assert property (
    dec_valid && !dec_fault && dec_mem_src
    |=> mem_elem_en == $past(lane_en_dec))
    else $error("memory element enables wrong");
  AST_ROUND: assert property (
    dec_valid && !dec_fault && dec_ext_prefix && dec_round_en
    |=> rd_round == $past(dec_round_mode))
    else $error("prefix rounding not applied");
  AST_REFUSE: assert property (
    dec_valid && dec_ext_prefix && dec_legacy_reg
    |=> rd_valid && rd_fault)
    else $error("prefix on legacy registers accepted");

  COV_ZERO_MASK: cover property (wb_ok && wb_zero
                                 && wb_mask_idx != MASK_REG_ZERO);
  COV_BCAST: cover property (dec_valid && dec_mem_src && dec_bcast);
  COV_SHORT: cover property (dec_valid && !s_q.long_mode ##1 rd_fault);
endmodule // vrf_top

// ### verif/tb_top.sv
// self-checking bench for the vector register file
`timescale 1ns/100ps
module tb_top;
  import vrf_pkg::*;
  logic                pclk;
  logic                presetn = 1'b0;
  logic [7:0]          paddr   = 8'h00;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [31:0]         pwdata  = 32'h0;
  logic [31:0]         prdata, rdat;
  logic                pready, pslverr, serr, rd_valid, rd_fault;
  logic                dec_valid, dec_ext_prefix, dec_legacy_reg, dec_esz;
  logic                dec_mem_src, dec_bcast, dec_round_en, wb_valid;
  logic                wb_zero, wb_esz, wb_kvalid;
  logic [4:0]          dec_dst, dec_src1, dec_src2, wb_dst;
  logic [2:0]          dec_mask_idx, dec_ksrc, wb_mask_idx, wb_kdst;
  logic [1:0]          dec_vl, dec_round_mode, wb_vl, rd_round;
  logic [VLEN-1:0]     mem_data, wb_data, rd_src1, rd_src2, p1, p2, p3, v;
  logic [KLEN-1:0]     wb_kdata, rd_pred, rd_ksrc;
  logic [KLEN-1:0]     kpat = 64'h0000_0000_0000_a5c3;
  vrf_lanes_t          mem_elem_en;
  int                  errors = 0;
  int                  comparisons = 0;

  vrf_top DUT (.*);
  vrf_far_model u_far (.*);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [VLEN-1:0] pat(input logic [31:0] s);
    logic [VLEN-1:0] r;
    for (int i = 0; i < 16; i++)
      r[32*i+:32] = s + 32'(i);
    return r;
  endfunction

  function automatic logic [VLEN-1:0] mrg(input logic [VLEN-1:0] o,
    input logic [VLEN-1:0] n, input logic [15:0] e, input logic z);
    logic [VLEN-1:0] r;
    for (int i = 0; i < 16; i++)
      r[32*i+:32] = e[i] ? n[32*i+:32] : (z ? 32'h0 : o[32*i+:32]);
    return r;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed latency assumed; answer taken at the access edge
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chv(input string nm, input logic [VLEN-1:0] e,
                     input logic [VLEN-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chw(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    p1 = pat(32'h1000_0000);
    p2 = pat(32'h2000_0000);
    p3 = pat(32'h3000_0000);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chw("ctrl", 64'h1, {32'h0, rdat});
    apb(1'b0, 8'h0c, 32'h0);
    chw("unmapped", 64'h1, {63'h0, serr});
    u_far.wb(5'h1f, p1, MASK_REG_ZERO, 1'b0, VL_512);
    u_far.wb(5'h01, p1, MASK_REG_ZERO, 1'b0, VL_128);
    u_far.wb(5'h02, p1, MASK_REG_ZERO, 1'b0, VL_256);
    u_far.dec(5'h1f, 5'h01, MASK_REG_ZERO, 3'h0, 5'h00, 2'h0, p2);
    chw("rd_valid", 64'h1, {63'h0, rd_valid});
    chv("v31", p1, rd_src1);
    chw("pred0", 64'hffff_ffff_ffff_ffff, rd_pred);
    chv("v1 narrow", {384'h0, p1[127:0]}, rd_src2);
    u_far.dec(5'h02, 5'h02, MASK_REG_ZERO, 3'h0, 5'h00, 2'h0, p2);
    chv("v2 half", {256'h0, p1[255:0]}, rd_src1);
    u_far.kw(3'h1, kpat);
    u_far.wb(5'h1f, p2, 3'h1, 1'b0, VL_512);
    u_far.dec(5'h1f, 5'h00, 3'h1, 3'h1, 5'h04, 2'h0, p2);
    v = mrg(p1, p2, kpat[15:0], 1'b0);
    chv("merge", v, rd_src1);
    chw("pred1", kpat, rd_pred);
    chw("ksrc1", kpat, rd_ksrc);
    u_far.wb(5'h1f, p3, 3'h1, 1'b1, VL_512);
    u_far.dec(5'h1f, 5'h00, 3'h1, 3'h1, 5'h04, 2'h0, p2);
    v = mrg(v, p3, kpat[15:0], 1'b1);
    chv("zeroing", v, rd_src1);
    // a mask with every element off: zeroing clears, merging keeps
    u_far.kw(3'h2, 64'h0);
    u_far.wb(5'h03, p1, MASK_REG_ZERO, 1'b0, VL_512);
    u_far.wb(5'h03, p2, 3'h2, 1'b1, VL_512);
    u_far.wb(5'h1f, p2, 3'h2, 1'b0, VL_512);
    u_far.dec(5'h03, 5'h1f, 3'h2, 3'h2, 5'h00, 2'h0, p2);
    chv("all off zero", 512'h0, rd_src1);
    chv("all off merge", v, rd_src2);
    chw("ksrc2", 64'h0, rd_ksrc);
    // dropped memory lanes must read zero, not stale data
    u_far.dec(5'h00, 5'h00, 3'h1, 3'h0, 5'h14, 2'h0, p3);
    chv("mem lanes", mrg(p1, p3, kpat[15:0], 1'b1), rd_src2);
    chw("mem en", {48'h0, kpat[15:0]}, {48'h0, mem_elem_en});
    u_far.dec(5'h00, 5'h00, 3'h0, 3'h0, 5'h1c, 2'h0, p3);
    chv("bcast", {16{p3[31:0]}}, rd_src2);
    // 64-bit elements take one mask bit per lane pair
    u_far.shape(1'b1, VL_256);
    u_far.dec(5'h00, 5'h00, 3'h1, 3'h0, 5'h14, 2'h0, p3);
    chw("mem en 64", 64'h000f, {48'h0, mem_elem_en});
    chv("mem 64", {384'h0, p3[127:0]}, rd_src2);
    u_far.wb(5'h04, p2, 3'h1, 1'b1, VL_512);
    u_far.shape(1'b1, VL_512);
    u_far.dec(5'h04, 5'h00, 3'h0, 3'h0, 5'h1c, 2'h0, p3);
    chv("zero 64", {p2[511:384], 256'h0, p2[127:0]}, rd_src1);
    chv("bcast 64", {8{p3[63:0]}}, rd_src2);
    u_far.shape(1'b0, VL_512);
    apb(1'b1, OFS_CTRL, 32'h5);
    u_far.dec(5'h00, 5'h00, 3'h0, 3'h0, 5'h04, 2'h3, p3);
    chw("round dflt", 64'h2, {62'h0, rd_round});
    for (int i = 0; i < 4; i++)
    begin
      u_far.dec(5'h00, 5'h00, 3'h0, 3'h0, 5'h05, 2'(i), p3);
      chw("round ovr", 64'(i), {62'h0, rd_round});
    end
    u_far.dec(5'h00, 5'h00, 3'h0, 3'h0, 5'h06, 2'h0, p3);
    chw("legacy", 64'h1, {63'h0, rd_fault});
    apb(1'b1, OFS_CTRL, 32'h0);
    u_far.wb(5'h09, p2, 3'h0, 1'b0, VL_512);
    u_far.dec(5'h08, 5'h07, 3'h0, 3'h0, 5'h00, 2'h0, p3);
    chw("short 8", 64'h1, {63'h0, rd_fault});
    u_far.dec(5'h07, 5'h07, 3'h0, 3'h0, 5'h00, 2'h0, p3);
    chw("short 7", 64'h0, {63'h0, rd_fault});
    apb(1'b1, OFS_CTRL, 32'h1);
    u_far.dec(5'h09, 5'h00, 3'h0, 3'h0, 5'h00, 2'h0, p3);
    chv("dropped", 512'h0, rd_src1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chw("faults", 64'h2, {32'h0, rdat});
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chw("cleared", 64'h0, {32'h0, rdat});
    conclude();
  end

  initial
  begin
    repeat (4000) @(posedge pclk);
    errors++;
    conclude();
  end
endmodule // tb_top

// ### verif/vrf_far_model.sv
// decoder and execution unit model driving the register file
`timescale 1ns/100ps
module vrf_far_model
  import vrf_pkg::*;
(
  input  wire logic            pclk,
  output logic                 dec_valid      = 1'b0,
  output logic                 dec_ext_prefix = 1'b0,
  output logic                 dec_legacy_reg = 1'b0,
  output logic [4:0]           dec_dst        = 5'h00,
  output logic [4:0]           dec_src1       = 5'h00,
  output logic [4:0]           dec_src2       = 5'h00,
  output logic [2:0]           dec_mask_idx   = 3'h0,
  output logic [2:0]           dec_ksrc       = 3'h0,
  output logic                 dec_esz        = 1'b0,
  output logic [1:0]           dec_vl         = 2'h2,
  output logic                 dec_mem_src    = 1'b0,
  output logic                 dec_bcast      = 1'b0,
  output logic                 dec_round_en   = 1'b0,
  output logic [1:0]           dec_round_mode = 2'h0,
  output logic [VLEN-1:0]      mem_data       = '0,
  output logic                 wb_valid       = 1'b0,
  output logic [4:0]           wb_dst         = 5'h00,
  output logic [VLEN-1:0]      wb_data        = '0,
  output logic [2:0]           wb_mask_idx    = 3'h0,
  output logic                 wb_zero        = 1'b0,
  output logic                 wb_esz         = 1'b0,
  output logic [1:0]           wb_vl          = 2'h2,
  output logic                 wb_kvalid      = 1'b0,
  output logic [2:0]           wb_kdst        = 3'h0,
  output logic [KLEN-1:0]      wb_kdata       = '0
);
  // fl packs mem source, broadcast, prefix, legacy regs, rounding enable
  task automatic dec(input logic [4:0] s1, input logic [4:0] s2,
                     input logic [2:0] mi, input logic [2:0] ks,
                     input logic [4:0] fl, input logic [1:0] rm,
                     input logic [VLEN-1:0] md);
    @(posedge pclk);
    dec_valid      <= 1'b1;
    dec_src1       <= s1;
    dec_src2       <= s2;
    dec_mask_idx   <= mi;
    dec_ksrc       <= ks;
    dec_round_mode <= rm;
    mem_data       <= md;
    {dec_mem_src, dec_bcast, dec_ext_prefix, dec_legacy_reg,
     dec_round_en} <= fl;
    @(posedge pclk);
    dec_valid      <= 1'b0;
    // answer is registered; look once it has settled
    @(negedge pclk);
  endtask

  task automatic wb(input logic [4:0] d, input logic [VLEN-1:0] v,
                    input logic [2:0] mi, input logic z,
                    input logic [1:0] vl);
    @(posedge pclk);
    wb_valid    <= 1'b1;
    wb_dst      <= d;
    wb_data     <= v;
    wb_mask_idx <= mi;
    wb_zero     <= z;
    wb_vl       <= vl;
    @(posedge pclk);
    wb_valid    <= 1'b0;
  endtask

  task automatic kw(input logic [2:0] d, input logic [KLEN-1:0] v);
    @(posedge pclk);
    wb_kvalid <= 1'b1;
    wb_kdst   <= d;
    wb_kdata  <= v;
    @(posedge pclk);
    wb_kvalid <= 1'b0;
  endtask

  // element size and decode length stay until changed again
  task automatic shape(input logic e, input logic [1:0] l);
    @(posedge pclk);
    dec_esz <= e;
    wb_esz  <= e;
    dec_vl  <= l;
  endtask
endmodule // vrf_far_model
